// File: rtl/fopu_defs.svh
// constant definitions for the float operand unpacker
// Contract
// [RL1] operand is 32 bits, bit 0 lowest byte
// [RL2] sign taken from bit 15, one means negative
// [RL3] exponent from bits 14..7, bias 128
// [RL4] 24-bit fraction with hidden leading one
// [RL5] fraction order bits 6..0 then 31..16
// [RL6] codes 1..255 give exponent minus bias
// [RL7] zero exponent, clear sign means zero
// [RL8] zero exponent, set sign raises reserved fault
// [RL9] integer literals zero-extend six bit field
// [RL10] float literals split into exponent, fraction parts
// [RL11] double extends fraction to 56 bits
// [RL12] outputs registered one clock, flags cleared on reset
`ifndef FOPU_DEFS_SVH
`define FOPU_DEFS_SVH

// field positions inside the first longword
`define FOPU_SIGN_BIT     15
`define FOPU_EXP_HI       14
`define FOPU_EXP_LO       7
`define FOPU_FHI_HI       6
`define FOPU_FHI_LO       0
`define FOPU_FW1_HI       31
`define FOPU_FW1_LO       16
// extra fraction words of a double operand
`define FOPU_FW2_HI       47
`define FOPU_FW2_LO       32
`define FOPU_FW3_HI       63
`define FOPU_FW3_LO       48
// exponent bias and special exponent code
`define FOPU_BIAS         9'h080
`define FOPU_EXP_ZERO     8'h00
// short literal layout and floating expansion base
`define FOPU_LIT_EXP_HI   5
`define FOPU_LIT_EXP_LO   3
`define FOPU_LIT_FRC_HI   2
`define FOPU_LIT_FRC_LO   0
`define FOPU_LIT_EXP_BASE 8'h80
// reset values
`define FOPU_RST_WORD     64'h0000_0000_0000_0000
`define FOPU_RST_FRAC     56'h00_0000_0000_0000
`define FOPU_RST_EXP      8'h00

`endif

// File: rtl/fopu_pkg.sv
// types shared by the float operand unpacker modules
package fopu_pkg;
    // operand data type presented with each operand
    typedef enum logic [2:0] {
        FOPU_BYTE   = 3'b000,
        FOPU_WORD   = 3'b001,
        FOPU_LONG   = 3'b010,
        FOPU_QUAD   = 3'b011,
        FOPU_FLOAT  = 3'b100,
        FOPU_DOUBLE = 3'b101
    } fopu_optype_t;
endpackage

// File: rtl/fopu_lit_if.sv
// carrier between the unpacker and its literal expander
interface fopu_lit_if;
    import fopu_pkg::*;
    logic [5:0]   literal;   // six bit literal field
    fopu_optype_t optype;    // data type of the operand
    logic [63:0]  operand;   // expanded operand
    modport expander (input literal, input optype, output operand);
    modport user     (output literal, output optype, input operand);
endinterface

// File: rtl/fopu_lit_expand.sv
// short literal expander: six bit field to full operand
`include "fopu_defs.svh"
module fopu_lit_expand (
    // carrier to the unpacker
    fopu_lit_if.expander lit
);
    import fopu_pkg::*;

    logic [2:0]  lit_exp;     // exponent part of literal
    logic [2:0]  lit_frc;     // fraction part of literal
    logic [7:0]  flt_exp;     // biased exponent of expansion
    logic [31:0] flt_word;    // first longword of float form
    logic        is_float;    // literal goes to floating form
    logic [63:0] int_word;    // zero-extended integer form

    // integer types just zero extend, giving 0..63
    assign int_word = {58'h0, lit.literal};                 // [RL9]

    // split literal into 3 bit exponent and 3 bit fraction
    assign lit_exp  = lit.literal[`FOPU_LIT_EXP_HI:`FOPU_LIT_EXP_LO];
    assign lit_frc  = lit.literal[`FOPU_LIT_FRC_HI:`FOPU_LIT_FRC_LO];
    assign flt_exp  = `FOPU_LIT_EXP_BASE + {5'h00, lit_exp};  // [RL10]
    // sign clear, exponent in 14..7, fraction in top 3 of 6..0
    assign flt_word = {16'h0000, 1'b0, flt_exp, lit_frc, 4'h0}; // [RL10]

    assign is_float = (lit.optype == FOPU_FLOAT) ||
                      (lit.optype == FOPU_DOUBLE);

    // double form keeps upper longword zero: fraction tail is zero
    assign lit.operand = is_float ? {32'h0000_0000, flt_word} : int_word;
endmodule

// File: rtl/fopu_unpack.sv
// float operand unpacker: classify and split floating operands
`include "fopu_defs.svh"
module fopu_unpack (
    // clock and reset
    input  wire logic                  i_clock,
    input  wire logic                  i_rst,
    // operand from the fetch path
    input  wire logic                  i_valid,
    input  wire fopu_pkg::fopu_optype_t i_optype,
    input  wire logic [63:0]           i_data,
    input  wire logic                  i_is_literal,
    input  wire logic [5:0]            i_literal,
    // unpacked operand to the floating datapath
    output logic                       o_valid,
    output logic [63:0]                o_operand,
    output logic                       o_sign,
    output logic [7:0]                 o_exp_biased,
    output logic [7:0]                 o_exp_true,
    output logic [55:0]                o_frac,
    output logic                       o_is_float,
    // classification flags
    output logic                       o_zero,
    output logic                       o_reserved,
    output logic                       o_fault
);
    import fopu_pkg::*;

    // carrier to the literal expander
    fopu_lit_if lit ();

    // literal path
    assign lit.literal = i_literal;
    assign lit.optype  = i_optype;

    fopu_lit_expand u_lit (
        .lit (lit.expander)
    );

    // selected operand and its fields
    logic [63:0] opnd;        // operand after literal selection
    logic        is_float;    // floating or double type
    logic        is_double;   // double type only
    logic        f_sign;      // sign bit
    logic [7:0]  f_exp;       // biased exponent code
    logic [8:0]  f_exp_diff;  // code minus bias, nine bits
    logic [7:0]  f_exp_true;  // true exponent, two's complement
    logic        exp_is_zero; // exponent code zero
    logic        f_zero;      // exact zero classification
    logic        f_resv;      // reserved classification
    logic [23:0] frac_single; // fraction with hidden bit, single
    logic [55:0] frac_double; // fraction with hidden bit, double
    logic [55:0] f_frac;      // fraction, left aligned

    // registered copies of the outputs
    logic        valid_r,    valid_nxt;
    logic [63:0] operand_r,  operand_nxt;
    logic        sign_r,     sign_nxt;
    logic [7:0]  expb_r,     expb_nxt;
    logic [7:0]  expt_r,     expt_nxt;
    logic [55:0] frac_r,     frac_nxt;
    logic        isflt_r,    isflt_nxt;
    logic        zero_r,     zero_nxt;
    logic        resv_r,     resv_nxt;
    logic        fault_r,    fault_nxt;

    // literal operands replace the fetched data word
    assign opnd = i_is_literal ? lit.operand : i_data;

    // type decode: integer types get no float classification
    assign is_double = (i_optype == FOPU_DOUBLE);
    assign is_float  = (i_optype == FOPU_FLOAT) || is_double;

    // bit 0 is in the lowest byte; the fetch path gathers the
    // bytes little-endian so opnd[31:0] is the 32-bit value  [RL1]
    assign f_sign = opnd[`FOPU_SIGN_BIT];                    // [RL2]
    assign f_exp  = opnd[`FOPU_EXP_HI:`FOPU_EXP_LO];         // [RL3]

    // true exponent is code minus 128; for codes 1..255 this
    // lands in -127..127 and fits eight signed bits
    assign f_exp_diff = {1'b0, f_exp} - `FOPU_BIAS;          // [RL6]
    assign f_exp_true = f_exp_diff[7:0];                     // [RL6]

    // zero code splits on sign; fraction bits are ignored
    assign exp_is_zero = (f_exp == `FOPU_EXP_ZERO);
    assign f_zero = is_float && exp_is_zero && !f_sign;      // [RL7]
    assign f_resv = is_float && exp_is_zero && f_sign;       // [RL8]

    // hidden one on top, then 6..0, then 31..16       [RL4] [RL5]
    assign frac_single = {1'b1,
                          opnd[`FOPU_FHI_HI:`FOPU_FHI_LO],
                          opnd[`FOPU_FW1_HI:`FOPU_FW1_LO]};

    // double continues with 47..32 and 63..48           [RL11]
    assign frac_double = {frac_single,
                          opnd[`FOPU_FW2_HI:`FOPU_FW2_LO],
                          opnd[`FOPU_FW3_HI:`FOPU_FW3_LO]};

    // single fraction is left aligned so the datapath sees one
    // format; a zero or reserved operand still shows its raw bits
    assign f_frac = !is_float  ? `FOPU_RST_FRAC :
                    is_double  ? frac_double :
                                 {frac_single, 32'h0000_0000};

    // next values: fields load only with a valid operand   [RL12]
    assign valid_nxt   = i_valid;
    assign operand_nxt = i_valid ? opnd : operand_r;
    assign sign_nxt    = i_valid ? (is_float && f_sign) : sign_r;
    assign expb_nxt    = i_valid ? (is_float ? f_exp : `FOPU_RST_EXP)
                                 : expb_r;
    // true exponent shown as zero for zero and reserved codes
    assign expt_nxt    = !i_valid ? expt_r :
                         (is_float && !exp_is_zero) ? f_exp_true :
                                                      `FOPU_RST_EXP;
    assign frac_nxt    = i_valid ? f_frac : frac_r;
    assign isflt_nxt   = i_valid ? is_float : isflt_r;
    assign zero_nxt    = i_valid ? f_zero : zero_r;
    assign resv_nxt    = i_valid ? f_resv : resv_r;
    // fault is a one-cycle event to the execution logic      [RL8]
    assign fault_nxt   = i_valid && f_resv;

    // output register stage, one clock of latency           [RL12]
    // each result field has its own short process so the reset value
    // and the load path sit side by side; the asynchronous clear
    // leaves every output low before the first clock arrives

    // result strobe, high one clock after each taken operand [RL12]
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            valid_r <= 1'b0;
        end else begin
            valid_r <= valid_nxt;
        end
    end

    // selected operand, held until the next one is taken     [RL12]
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            operand_r <= `FOPU_RST_WORD;
        end else begin
            operand_r <= operand_nxt;
        end
    end

    // sign bit, forced low for integer types                 [RL2]
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            sign_r <= 1'b0;
        end else begin
            sign_r <= sign_nxt;
        end
    end

    // biased exponent code                                    [RL3]
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            expb_r <= `FOPU_RST_EXP;
        end else begin
            expb_r <= expb_nxt;
        end
    end

    // true exponent; zero for the zero and reserved codes     [RL6]
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            expt_r <= `FOPU_RST_EXP;
        end else begin
            expt_r <= expt_nxt;
        end
    end

    // left aligned fraction with its hidden one  [RL4] [RL5] [RL11]
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            frac_r <= `FOPU_RST_FRAC;
        end else begin
            frac_r <= frac_nxt;
        end
    end

    // floating type marker, held with the fields             [RL12]
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            isflt_r <= 1'b0;
        end else begin
            isflt_r <= isflt_nxt;
        end
    end

    // exact zero level, held so the datapath may test it late [RL7]
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            zero_r <= 1'b0;
        end else begin
            zero_r <= zero_nxt;
        end
    end

    // reserved level, held beside the one-cycle fault         [RL8]
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            resv_r <= 1'b0;
        end else begin
            resv_r <= resv_nxt;
        end
    end

    // fault pulse; a held level would raise the fault again on
    // every idle cycle, so it drops when no operand is taken  [RL8]
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            fault_r <= 1'b0;
        end else begin
            fault_r <= fault_nxt;
        end
    end

    // outputs straight from the flip-flops
    assign o_valid      = valid_r;
    assign o_operand    = operand_r;
    assign o_sign       = sign_r;
    assign o_exp_biased = expb_r;
    assign o_exp_true   = expt_r;
    assign o_frac       = frac_r;
    assign o_is_float   = isflt_r;
    assign o_zero       = zero_r;
    assign o_reserved   = resv_r;
    assign o_fault      = fault_r;
endmodule

// File: tb/fopu_unpack_assertions.sv
// port checker for the float operand unpacker
module fopu_unpack_assertions import fopu_pkg::*; (
    // clock and reset
    input wire logic         i_clock,
    input wire logic         i_rst,
    // operand side
    input wire logic         i_valid,
    input wire logic         i_is_literal,
    input wire fopu_optype_t i_optype,
    input wire logic [5:0]   i_literal,
    // result side
    input wire logic         o_valid,
    input wire logic         o_sign,
    input wire logic         o_is_float,
    input wire logic         o_zero,
    input wire logic         o_reserved,
    input wire logic         o_fault,
    input wire logic [63:0]  o_operand,
    input wire logic [7:0]   o_exp_biased,
    input wire logic [7:0]   o_exp_true,
    input wire logic [55:0]  o_frac
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // a float result on show this cycle
    wire flt = o_valid && o_is_float;
    // zero exponent code on a float result
    wire ez = flt && o_exp_biased == 8'h00;
    lat_one_a: assert property (i_valid |=> o_valid)
        else $error("result late");
    no_spur_a: assert property (!i_valid |=> !o_valid && !o_fault)
        else $error("spurious result");
    held_out_a: assert property (!i_valid |=> $stable(o_frac))
        else $error("fraction not held");
    sign_pos_a: assert property (flt |-> o_sign == o_operand[15])
        else $error("sign bit wrong");
    exp_field_a: assert property (flt |->
        o_exp_biased == o_operand[14:7])
        else $error("exponent field wrong");
    hidden_one_a: assert property (flt |-> o_frac[55])
        else $error("hidden one missing");
    frac_order_a: assert property (flt |->
        o_frac[54:32] == {o_operand[6:0], o_operand[31:16]})
        else $error("fraction order wrong");
    exp_bias_a: assert property (flt && !ez |->
        o_exp_true == o_exp_biased - 8'h80) else $error("bias wrong");
    zero_class_a: assert property (o_valid |->
        o_zero == (ez && !o_sign)) else $error("zero class wrong");
    res_fault_a: assert property (o_valid |->
        o_fault == (ez && o_sign) && o_reserved == o_fault)
        else $error("reserved wrong");
    lit_int_a: assert property (i_valid && i_is_literal &&
        i_optype[2:1] != 2'b10 |=> o_operand == {58'h0, $past(i_literal)})
        else $error("literal not zero extended");
    // floating literal: exponent part over the base, fraction on top
    lit_flt_a: assert property (i_valid && i_is_literal &&
        i_optype[2:1] == 2'b10 |=> o_operand == {49'h0,
        8'h80 + {5'h00, $past(i_literal[5:3])},
        $past(i_literal[2:0]), 4'h0})
        else $error("literal not expanded to floating");
    cover property (o_fault);
    cover property (o_valid && o_zero);
    cover property (i_valid [*3]);
endmodule
bind fopu_unpack fopu_unpack_assertions u_fopu_unpack_assertions (
    .i_clock, .i_rst, .i_valid, .i_is_literal, .i_optype, .i_literal,
    .o_valid, .o_sign, .o_is_float, .o_zero, .o_reserved, .o_fault,
    .o_operand, .o_exp_biased, .o_exp_true, .o_frac);

// File: tb/fopu_sink.sv
// far side model: datapath counting results and faults it takes
module fopu_sink (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    // result strobes from the unpacker
    input  wire logic        i_valid,
    input  wire logic        i_fault,
    // running counts
    output logic [31:0]      o_ops,
    output logic [31:0]      o_faults
);
    timeunit 1ns;
    timeprecision 1ps;
    // a fault only counts on a result cycle, as the datapath sees it
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_ops <= 32'h0;
            o_faults <= 32'h0;
        end else begin
            o_ops <= o_ops + 32'(i_valid);
            o_faults <= o_faults + 32'(i_valid & i_fault);
        end
    end
endmodule

// File: tb/tb_fopu_unpack.sv
// self-checking bench for the float operand unpacker
module tb_fopu_unpack import fopu_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock = 1'b0, i_rst = 1'b1, i_valid = 1'b0, i_is_literal = 1'b0;
    fopu_optype_t i_optype = FOPU_BYTE;
    logic [63:0] i_data = 64'h0, o_operand, e_op = 64'h0;
    logic [5:0] i_literal = 6'h00;
    logic o_valid, o_sign, o_is_float, o_zero, o_reserved, o_fault;
    logic [7:0] o_exp_biased, o_exp_true, e_eb = 8'h00, e_et = 8'h00;
    logic [55:0] o_frac, e_frac = 56'h0;
    // expectations except pv load only when an operand is taken
    logic e_s = 1'b0, e_f = 1'b0, e_z = 1'b0, e_r = 1'b0, pv = 1'b0;
    logic [31:0] rnd = 32'hCD319B26, s_ops, s_flt;
    int fail_count = 0, tests_run = 0, cyc = 0, n_ops = 0, n_flt = 0;
    fopu_unpack u_fopu_unpack (.i_clock, .i_rst, .i_valid, .i_optype,
        .i_data, .i_is_literal, .i_literal, .o_valid, .o_operand, .o_sign,
        .o_exp_biased, .o_exp_true, .o_frac, .o_is_float, .o_zero,
        .o_reserved, .o_fault);
    fopu_sink u_fopu_sink (.i_clock, .i_rst, .i_valid(o_valid),
        .i_fault(o_fault), .o_ops(s_ops), .o_faults(s_flt));
    initial forever #12.5 i_clock = ~i_clock;
    function automatic logic [63:0] lit_op(input logic fl, input [5:0] lt);
        return fl ? {49'h0, 8'h80 + {5'h0, lt[5:3]}, lt[2:0], 4'h0}
                  : {58'h0, lt};
    endfunction
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [63:0] seen, input logic [63:0] want);
        tests_run++;
        if (seen !== want) begin
            fail_count++;
            $display("unexpected at %0t: %h not %h", $time, seen, want);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // drive one cycle, then judge what the previous cycle handed in
    task automatic step(input logic v, input logic [2:0] t,
        input logic [63:0] d, input logic l, input logic [5:0] lt);
        logic fl;
        logic [63:0] op;
        fl = t == FOPU_FLOAT || t == FOPU_DOUBLE;
        op = l ? lit_op(fl, lt) : d;
        @(posedge i_clock);
        i_valid <= v;
        i_optype <= fopu_optype_t'(t);
        i_data <= d;
        i_is_literal <= l;
        i_literal <= lt;
        @(negedge i_clock);
        chk(o_valid, pv);
        chk(o_fault, pv & e_r);
        chk(o_operand, e_op);
        chk(o_is_float, e_f);
        chk(o_sign, e_s);
        chk({o_exp_biased, o_exp_true}, {e_eb, e_et});
        chk(o_frac, e_frac);
        chk({o_zero, o_reserved}, {e_z, e_r});
        pv = v;
        if (v) begin
            n_ops++;
            e_op = op;
            e_f = fl;
            e_s = fl & op[15];
            e_eb = fl ? op[14:7] : 8'h00;
            e_et = e_eb == 8'h00 ? 8'h00 : e_eb - 8'h80;
            e_frac = !fl ? 56'h0 : {1'b1, op[6:0], op[31:16],
                t == FOPU_DOUBLE ? {op[47:32], op[63:48]} : 32'h0};
            e_z = e_f && e_eb == 8'h00 && !e_s;
            e_r = e_f && e_eb == 8'h00 && e_s;
            n_flt += int'(e_r);
        end
    endtask
    // hang guard, well above the roughly 2040 cycles of the run
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            results();
        end
    end
    initial begin
        repeat (16) @(posedge i_clock);
        i_rst <= 1'b0;
        // exponent extremes, zero with junk fraction, reserved, double
        step(1, 3'b100, 64'h0000_4080, 0, 0);
        step(1, 3'b100, 64'h0000_8000, 0, 0);
        step(1, 3'b100, 64'hFFFF_FFFF_FFFF_007F, 0, 0);
        step(1, 3'b100, 64'h0000_7F80, 0, 0);
        step(1, 3'b101, 64'h1234_5678_9ABC_00C1, 0, 0);
        step(0, 3'b100, 64'h0, 0, 0);
        // every operand type through the literal path
        for (int i = 0; i < 8; i++)
            step(1, i[2:0], 64'hFFFF_FFFF_FFFF_FFFF, 1,
                 6'h3F - 6'(i));
        // mid-run reset while a result is on show: all must clear
        @(posedge i_clock);
        i_rst <= 1'b1;
        i_valid <= 1'b0;
        @(negedge i_clock);
        chk({o_valid, o_fault, o_zero, o_reserved}, 4'h0);
        chk({o_is_float, o_sign}, 2'h0);
        chk({o_exp_biased, o_exp_true}, 16'h0000);
        chk(o_frac, 56'h0);
        chk(o_operand, 64'h0);
        chk({s_ops, s_flt}, 64'h0);
        repeat (2) @(posedge i_clock);
        i_rst <= 1'b0;
        // expectations and counts restart with the cleared design
        {pv, e_f, e_s, e_z, e_r} = 5'h00;
        {e_op, e_eb, e_et, e_frac} = 136'h0;
        n_ops = 0;
        n_flt = 0;
        repeat (2000) begin
            rnd = lfsr(rnd);
            step(rnd[0] | rnd[1], rnd[4:2], {lfsr(rnd), rnd},
                 rnd[5] & rnd[6], rnd[12:7]);
        end
        // two idle cycles so the sink has counted the last result
        step(0, 3'b000, 64'h0, 0, 0);
        step(0, 3'b000, 64'h0, 0, 0);
        chk(s_ops, n_ops);
        chk(s_flt, n_flt);
        results();
    end
endmodule
